// file: prog_reg_model.sv
// Purpose: Program memory and register file beside the executor
// Assumes: Both answer combinationally to the registered addresses
// Notes:   The testbench loads both arrays directly
`timescale 1ns/1ps
`default_nettype none
module prog_reg_model #(
  parameter int PC_W = 16  // Program counter width
) (
  input wire logic            sys_clk,    // Core clock
  input wire logic [PC_W-1:0] fetchAddr,  // Program address
  input wire logic [7:0]      regRdAddr,  // Register read address
  input wire relative_jump_and_load_pkg::reg_write_type regWr, // Register write
  output logic [7:0]          fetchData,  // Program byte
  output logic [7:0]          regRdData   // Register byte
);
  logic [7:0] prog [256];
  logic [7:0] regs [256];
  // Same-cycle answers
  assign fetchData = prog[fetchAddr[7:0]];
  assign regRdData = regs[regRdAddr];
  // Register write at the clock edge
  always @(posedge sys_clk) begin
    if (regWr.en) regs[regWr.addr] <= regWr.data;
  end
endmodule : prog_reg_model
`default_nettype wire

// file: relative_jump_and_load_exec.sv
// Purpose: Fetch, decode and execute the conditional relative branch and the
//          byte move instruction family, one instruction at a time.
// Assumes: fetchData and regRdData answer combinationally to the registered
//          fetchAddr and regRdAddr in the same cycle; both are same-clock.
// Notes:   Each instruction spans a fixed number of cycles from its opcode
//          cycle to the next opcode cycle.
// Operation
// - A branch whose condition holds adds the displacement to the counter, else falls through.
// - The displacement is added to the address of the byte after the two-byte branch.
// - The branch opcode holds the condition selector in its upper nibble, the code in its lower.
// - A byte move copies source to destination and never alters the source.
// - Low nibbles C, 8 and 9 give immediate, from-register and to-register moves of 4 cycles.
// - C7 loads a working register indirectly and D7 stores indirectly, each 4 cycles.
// - E4 copies register to register and E5 copies from an indirect source, each 6 cycles.
// - F5 copies a register to a location addressed through another register in 6 cycles.
// - 87 and 97 load and store at a base byte plus a working index register in 6 cycles.
`timescale 1ns/1ps
`default_nettype none
module relative_jump_and_load_exec #(
  parameter int              PC_W     = 16,      // Program counter width
  parameter logic [PC_W-1:0] PC_RESET = '0       // Program counter after reset
) (
  input  wire logic              sys_clk,        // Core clock
  input  wire logic              sys_rst,        // Synchronous reset, active high
  input  wire logic [7:0]        fetchData,      // Program byte at fetchAddr
  input  wire logic [7:0]        regRdData,      // Register byte at regRdAddr
  input  wire logic [7:0]        flags,          // Flags byte, read only
  input  wire logic [7:0]        workBase,       // Register number of working reg 0
  output logic      [PC_W-1:0]   fetchAddr,      // Program counter
  output logic      [7:0]        regRdAddr,      // Register read address
  output relative_jump_and_load_pkg::reg_write_type regWr, // Register write
  output logic                   instrDone,      // High in the opcode cycle after an instruction
  output logic                   badOpcode       // Unknown opcode skipped
);
  // Elaboration check: the sign extension needs more than 8 counter bits
  if (PC_W < 9 || PC_W > 32) begin : g_pcWidthCheck
    $error("PC_W must lie in 9..32");
  end

  typedef struct packed {
    relative_jump_and_load_pkg::phase_type     phase;
    relative_jump_and_load_pkg::op_kind_type   kind;
    logic [2:0]                                cnt;
    logic [2:0]                                cycles;
    logic [1:0]                                len;
    logic [7:0]                                opc;
    logic [7:0]                                b2;
    logic [7:0]                                tmp;
    logic                                      taken;
    logic [PC_W-1:0]                           pc;
    logic [7:0]                                rdAddr;
    relative_jump_and_load_pkg::reg_write_type wr;
    logic                                      done;
    logic                                      bad;
  } exec_state_type;

  exec_state_type cur_ff;
  exec_state_type nxt_cur;
  logic           condTrue;
  relative_jump_and_load_pkg::op_kind_type newKind;

  // Condition nibble taken from the opcode byte as it arrives
  condition_eval condEval (
    .condSel  (fetchData[7:4]),
    .flags    (flags),
    .condTrue (condTrue)
  );

  assign newKind = relative_jump_and_load_pkg::opKind(fetchData);

  // Next state: decode, operand steps and the closing cycle
  always_comb begin
    nxt_cur         = cur_ff;
    nxt_cur.wr.en   = 1'b0;
    nxt_cur.done    = 1'b0;
    nxt_cur.bad     = 1'b0;
    nxt_cur.cnt     = 3'(cur_ff.cnt + 3'h1);
    case (cur_ff.phase)
      relative_jump_and_load_pkg::OPCODE_ST: begin
        nxt_cur.opc   = fetchData;
        nxt_cur.kind  = newKind;
        nxt_cur.pc    = PC_W'(cur_ff.pc + 1'b1);
        nxt_cur.taken = condTrue;
        nxt_cur.cnt   = 3'h1;
        nxt_cur.phase = relative_jump_and_load_pkg::EXEC_ST;
        case (newKind)
          relative_jump_and_load_pkg::K_BRANCH: begin
            nxt_cur.len    = relative_jump_and_load_pkg::LEN_TWO;
            nxt_cur.cycles = relative_jump_and_load_pkg::CYC_LONG;
          end
          relative_jump_and_load_pkg::K_IMM_WORK, relative_jump_and_load_pkg::K_REG_WORK,
          relative_jump_and_load_pkg::K_WORK_REG, relative_jump_and_load_pkg::K_WIND_LD,
          relative_jump_and_load_pkg::K_WIND_ST: begin
            nxt_cur.len    = relative_jump_and_load_pkg::LEN_TWO;
            nxt_cur.cycles = relative_jump_and_load_pkg::CYC_SHORT;
          end
          relative_jump_and_load_pkg::K_BAD: begin
            nxt_cur.len    = relative_jump_and_load_pkg::LEN_ONE;
            nxt_cur.cycles = relative_jump_and_load_pkg::CYC_SHORT;
            nxt_cur.bad    = 1'b1;
          end
          default: begin
            nxt_cur.len    = relative_jump_and_load_pkg::LEN_THREE;
            nxt_cur.cycles = relative_jump_and_load_pkg::CYC_LONG;
          end
        endcase
      end
      relative_jump_and_load_pkg::EXEC_ST: begin
        // Operand bytes advance the counter past the whole instruction
        if ({1'b0, cur_ff.cnt} < {2'b00, cur_ff.len}) begin
          nxt_cur.pc = PC_W'(cur_ff.pc + 1'b1);
        end
        // Second byte cycle
        if (cur_ff.cnt == 3'h1 && cur_ff.len != relative_jump_and_load_pkg::LEN_ONE) begin
          nxt_cur.b2 = fetchData;
          case (cur_ff.kind)
            relative_jump_and_load_pkg::K_BRANCH:   nxt_cur.tmp = fetchData;
            relative_jump_and_load_pkg::K_IMM_WORK: begin
              nxt_cur.wr = '{1'b1, relative_jump_and_load_pkg::workAddr(workBase,
                             cur_ff.opc[7:4]), fetchData};
            end
            relative_jump_and_load_pkg::K_REG_WORK: nxt_cur.rdAddr = fetchData;
            relative_jump_and_load_pkg::K_WORK_REG: begin
              nxt_cur.rdAddr = relative_jump_and_load_pkg::workAddr(workBase, cur_ff.opc[7:4]);
            end
            relative_jump_and_load_pkg::K_WIND_LD, relative_jump_and_load_pkg::K_IDX_LD,
            relative_jump_and_load_pkg::K_IDX_ST: begin
              nxt_cur.rdAddr = relative_jump_and_load_pkg::workAddr(workBase, fetchData[3:0]);
            end
            relative_jump_and_load_pkg::K_WIND_ST: begin
              nxt_cur.rdAddr = relative_jump_and_load_pkg::workAddr(workBase, fetchData[7:4]);
            end
            relative_jump_and_load_pkg::K_IMM_REG: nxt_cur.rdAddr = cur_ff.rdAddr;
            default: nxt_cur.rdAddr = fetchData;
          endcase
        end
        // Third byte cycle, first register answer available
        if (cur_ff.cnt == 3'h2) begin
          case (cur_ff.kind)
            relative_jump_and_load_pkg::K_REG_WORK: begin
              nxt_cur.wr = '{1'b1, relative_jump_and_load_pkg::workAddr(workBase,
                             cur_ff.opc[7:4]), regRdData};
            end
            relative_jump_and_load_pkg::K_WORK_REG: begin
              nxt_cur.wr = '{1'b1, cur_ff.b2, regRdData};
            end
            relative_jump_and_load_pkg::K_WIND_LD:  nxt_cur.rdAddr = regRdData;
            relative_jump_and_load_pkg::K_WIND_ST: begin
              nxt_cur.tmp    = regRdData;
              nxt_cur.rdAddr = relative_jump_and_load_pkg::workAddr(workBase, cur_ff.b2[3:0]);
            end
            relative_jump_and_load_pkg::K_REG_REG: begin
              nxt_cur.wr = '{1'b1, fetchData, regRdData};
            end
            relative_jump_and_load_pkg::K_RIND_REG: begin
              nxt_cur.rdAddr = regRdData;
              nxt_cur.tmp    = fetchData;
            end
            relative_jump_and_load_pkg::K_IMM_REG: begin
              nxt_cur.wr = '{1'b1, cur_ff.b2, fetchData};
            end
            relative_jump_and_load_pkg::K_IMM_RIND: begin
              nxt_cur.wr = '{1'b1, regRdData, fetchData};
            end
            relative_jump_and_load_pkg::K_REG_RIND: begin
              nxt_cur.tmp    = regRdData;
              nxt_cur.rdAddr = fetchData;
            end
            relative_jump_and_load_pkg::K_IDX_LD: begin
              nxt_cur.rdAddr = 8'(fetchData + regRdData);
            end
            relative_jump_and_load_pkg::K_IDX_ST: begin
              nxt_cur.tmp    = 8'(fetchData + regRdData);
              nxt_cur.rdAddr = relative_jump_and_load_pkg::workAddr(workBase, cur_ff.b2[7:4]);
            end
            default: nxt_cur.wr.en = 1'b0;
          endcase
        end
        // Final data cycle of the indirect and indexed forms other than D6, which writes in the third byte cycle
        if (cur_ff.cnt == 3'h3) begin
          case (cur_ff.kind)
            relative_jump_and_load_pkg::K_WIND_LD, relative_jump_and_load_pkg::K_IDX_LD: begin
              nxt_cur.wr = '{1'b1, relative_jump_and_load_pkg::workAddr(workBase,
                             cur_ff.b2[7:4]), regRdData};
            end
            relative_jump_and_load_pkg::K_WIND_ST, relative_jump_and_load_pkg::K_RIND_REG,
            relative_jump_and_load_pkg::K_IDX_ST: begin
              nxt_cur.wr = '{1'b1, cur_ff.tmp, regRdData};
            end
            relative_jump_and_load_pkg::K_REG_RIND: begin
              nxt_cur.wr = '{1'b1, regRdData, cur_ff.tmp};
            end
            default: nxt_cur.wr.en = 1'b0;
          endcase
        end
        // Closing cycle: branch target or fall through, then next opcode
        if (cur_ff.cnt == 3'(cur_ff.cycles - 3'h1)) begin
          nxt_cur.phase = relative_jump_and_load_pkg::OPCODE_ST;
          nxt_cur.done  = 1'b1;
          if (cur_ff.kind == relative_jump_and_load_pkg::K_BRANCH && cur_ff.taken) begin
            nxt_cur.pc = PC_W'(cur_ff.pc + {{(PC_W-8){cur_ff.tmp[7]}}, cur_ff.tmp});
          end
        end
      end
      default: nxt_cur.phase = relative_jump_and_load_pkg::OPCODE_ST;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_ff        <= '0;
      cur_ff.phase  <= relative_jump_and_load_pkg::OPCODE_ST;
      cur_ff.kind   <= relative_jump_and_load_pkg::K_BAD;
      cur_ff.pc     <= PC_RESET;
      cur_ff.rdAddr <= relative_jump_and_load_pkg::BYTE_ZERO;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from the state register; no flag output exists
  assign fetchAddr = cur_ff.pc;
  assign regRdAddr = cur_ff.rdAddr;
  assign regWr     = cur_ff.wr;
  assign instrDone = cur_ff.done;
  assign badOpcode = cur_ff.bad;
endmodule : relative_jump_and_load_exec
`default_nettype wire

// file: relative_jump_and_load_exec_properties.sv
// Purpose: Port-level properties of the branch and byte move executor
// Assumes: Cycle 0 is the first cycle after reset release or a cycle with instrDone high
// Notes:   Helper flops hold opcode, its address, byte 2 and cycle index
`timescale 1ns/1ps
`default_nettype none
module relative_jump_and_load_exec_properties #(
  parameter int PC_W = 16  // Program counter width
) (
  input wire logic            sys_clk,    // Core clock
  input wire logic            sys_rst,    // Synchronous reset
  input wire logic [7:0]      fetchData,  // Program byte
  input wire logic [7:0]      regRdData,  // Register byte
  input wire logic [7:0]      flags,      // Flags byte
  input wire logic [7:0]      workBase,   // Working register base
  input wire logic [PC_W-1:0] fetchAddr,  // Program counter
  input wire logic [7:0]      regRdAddr,  // Register read address
  input wire relative_jump_and_load_pkg::reg_write_type regWr, // Register write
  input wire logic            instrDone,  // Next opcode cycle
  input wire logic            badOpcode   // Unknown opcode
);
  logic [2:0]      cyc_ff;
  logic            wasRst_ff;
  logic [7:0]      opc_ff;
  logic [7:0]      byte2_ff;
  logic [PC_W-1:0] pcOp_ff;
  logic            isOp;
  logic [PC_W-1:0] target;
  // Opcode cycle and taken branch address
  assign isOp = !sys_rst && (wasRst_ff || instrDone);
  assign target = pcOp_ff + PC_W'(2) + {{(PC_W-8){byte2_ff[7]}}, byte2_ff};
  // Kind of opcode: 0 unknown, 1 four-cycle, 2 six-cycle
  function automatic logic [1:0] kindOf(input logic [7:0] op);
    if (op[3:0] inside {4'h8, 4'h9, 4'hC} || op inside {8'hC7, 8'hD7}) return 2'h1;
    if (op[3:0] == 4'hB || op inside {8'hE4, 8'hE5, 8'hE6, 8'hD6, 8'hF5, 8'h87, 8'h97})
      return 2'h2;
    return 2'h0;
  endfunction : kindOf
  // Cycle index since the opcode cycle, saturating at 7
  always_ff @(posedge sys_clk) begin
    wasRst_ff <= sys_rst;
    if (sys_rst) cyc_ff <= 3'h7;
    else if (isOp) cyc_ff <= 3'h1;
    else if (cyc_ff != 3'h7) cyc_ff <= cyc_ff + 3'h1;
    if (isOp) opc_ff <= fetchData;
    if (isOp) pcOp_ff <= fetchAddr;
    if (cyc_ff == 3'h1) byte2_ff <= fetchData;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_pulse; badOpcode ##1 !badOpcode; endsequence
  sequence s_quiet; !regWr.en [*3]; endsequence
  property p_shortLen; instrDone && kindOf(opc_ff) != 2'h2 |-> cyc_ff == 3'h4; endproperty
  a_shortLen: assert property (p_shortLen) else $error("short form length wrong");
  property p_longLen;
    instrDone && kindOf(opc_ff) == 2'h2 && opc_ff[3:0] != 4'hB |-> cyc_ff == 3'h6;
  endproperty
  a_longLen: assert property (p_longLen) else $error("long length wrong");
  property p_branchLen; instrDone && opc_ff[3:0] == 4'hB |-> cyc_ff == 3'h6; endproperty
  a_branchLen: assert property (p_branchLen) else $error("branch length wrong");
  property p_noHang; cyc_ff == 3'h7 |-> wasRst_ff; endproperty
  a_noHang: assert property (p_noHang) else $error("instruction overran");
  property p_taken; instrDone && opc_ff == 8'h8B |-> fetchAddr == target; endproperty
  a_taken: assert property (p_taken) else $error("taken branch address wrong");
  property p_fallThru;
    instrDone && opc_ff == 8'h0B |-> fetchAddr == pcOp_ff + PC_W'(2);
  endproperty
  a_fallThru: assert property (p_fallThru) else $error("untaken branch address wrong");
  property p_nextSeq;
    instrDone && opc_ff[3:0] != 4'hB |-> fetchAddr == pcOp_ff + PC_W'(kindOf(opc_ff) + 2'h1);
  endproperty
  a_nextSeq: assert property (p_nextSeq) else $error("next opcode address wrong");
  property p_badPulse; isOp && kindOf(fetchData) == 2'h0 |=> s_pulse and s_quiet; endproperty
  a_badPulse: assert property (p_badPulse) else $error("unknown opcode handling wrong");
  property p_immWrite;
    cyc_ff == 3'h2 && opc_ff[3:0] == 4'hC |-> regWr.en && regWr.data == byte2_ff
      && regWr.addr == 8'(workBase + {4'h0, opc_ff[7:4]});
  endproperty
  a_immWrite: assert property (p_immWrite) else $error("immediate write wrong");
endmodule : relative_jump_and_load_exec_properties
`default_nettype wire

// file: relative_jump_and_load_pkg.sv
// Purpose: Shared constants and types for the relative jump and byte move
//          executor, plus the condition evaluator that the executor uses.
// Assumes: Program memory and register file answer combinationally to the
//          registered addresses that the executor drives.
// Notes:   Condition encoding and flag positions are local choices.
package relative_jump_and_load_pkg;
  // Opcode nibbles and full opcodes
  localparam logic [3:0] NIB_BRANCH    = 4'hB;
  localparam logic [3:0] NIB_IMM_WORK  = 4'hC;
  localparam logic [3:0] NIB_REG_WORK  = 4'h8;
  localparam logic [3:0] NIB_WORK_REG  = 4'h9;
  localparam logic [7:0] OPC_WIND_LD   = 8'hC7;
  localparam logic [7:0] OPC_WIND_ST   = 8'hD7;
  localparam logic [7:0] OPC_REG_REG   = 8'hE4;
  localparam logic [7:0] OPC_RIND_REG  = 8'hE5;
  localparam logic [7:0] OPC_IMM_REG   = 8'hE6;
  localparam logic [7:0] OPC_IMM_RIND  = 8'hD6;
  localparam logic [7:0] OPC_REG_RIND  = 8'hF5;
  localparam logic [7:0] OPC_IDX_LD    = 8'h87;
  localparam logic [7:0] OPC_IDX_ST    = 8'h97;

  // Instruction lengths in bytes and durations in cycles
  localparam logic [1:0] LEN_ONE       = 2'h1;
  localparam logic [1:0] LEN_TWO       = 2'h2;
  localparam logic [1:0] LEN_THREE     = 2'h3;
  localparam logic [2:0] CYC_SHORT     = 3'h4;
  localparam logic [2:0] CYC_LONG      = 3'h6;

  // Flag bit positions in the flags byte
  localparam int FLAG_CARRY = 7;
  localparam int FLAG_ZERO  = 6;
  localparam int FLAG_SIGN  = 5;
  localparam int FLAG_OVFL  = 4;

  // Condition selector encodings
  localparam logic [3:0] CC_NEVER = 4'h0;
  localparam logic [3:0] CC_LT    = 4'h1;
  localparam logic [3:0] CC_LE    = 4'h2;
  localparam logic [3:0] CC_ULE   = 4'h3;
  localparam logic [3:0] CC_OV    = 4'h4;
  localparam logic [3:0] CC_MI    = 4'h5;
  localparam logic [3:0] CC_EQ    = 4'h6;
  localparam logic [3:0] CC_CY    = 4'h7;
  localparam logic [3:0] CC_ALL   = 4'h8;
  localparam logic [3:0] CC_GE    = 4'h9;
  localparam logic [3:0] CC_GT    = 4'hA;
  localparam logic [3:0] CC_UGT   = 4'hB;
  localparam logic [3:0] CC_NOV   = 4'hC;
  localparam logic [3:0] CC_PL    = 4'hD;
  localparam logic [3:0] CC_NE    = 4'hE;
  localparam logic [3:0] CC_NC    = 4'hF;

  // Reset values
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {OPCODE_ST, EXEC_ST} phase_type;

  typedef enum logic [3:0] {
    K_BAD, K_BRANCH, K_IMM_WORK, K_REG_WORK, K_WORK_REG, K_WIND_LD, K_WIND_ST,
    K_REG_REG, K_RIND_REG, K_IMM_REG, K_IMM_RIND, K_REG_RIND, K_IDX_LD, K_IDX_ST
  } op_kind_type;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

  // Classify an opcode byte
  function automatic op_kind_type opKind(input logic [7:0] opc);
    op_kind_type k;
    k = K_BAD;
    case (opc[3:0])
      NIB_BRANCH:   k = K_BRANCH;
      NIB_IMM_WORK: k = K_IMM_WORK;
      NIB_REG_WORK: k = K_REG_WORK;
      NIB_WORK_REG: k = K_WORK_REG;
      default: begin
        case (opc)
          OPC_WIND_LD:  k = K_WIND_LD;
          OPC_WIND_ST:  k = K_WIND_ST;
          OPC_REG_REG:  k = K_REG_REG;
          OPC_RIND_REG: k = K_RIND_REG;
          OPC_IMM_REG:  k = K_IMM_REG;
          OPC_IMM_RIND: k = K_IMM_RIND;
          OPC_REG_RIND: k = K_REG_RIND;
          OPC_IDX_LD:   k = K_IDX_LD;
          OPC_IDX_ST:   k = K_IDX_ST;
          default:      k = K_BAD;
        endcase
      end
    endcase
    return k;
  endfunction : opKind

  // Register address of working register n
  function automatic logic [7:0] workAddr(input logic [7:0] base, input logic [3:0] n);
    return 8'(base + {4'h0, n});
  endfunction : workAddr
endpackage : relative_jump_and_load_pkg

`timescale 1ns/1ps
`default_nettype none
// Evaluates a condition selector against the flags byte
module condition_eval (
  input  wire logic [3:0] condSel,   // Condition selector nibble
  input  wire logic [7:0] flags,     // Current flags byte
  output logic            condTrue   // Condition holds
);
  logic c, z, s, v;
  assign c = flags[relative_jump_and_load_pkg::FLAG_CARRY];
  assign z = flags[relative_jump_and_load_pkg::FLAG_ZERO];
  assign s = flags[relative_jump_and_load_pkg::FLAG_SIGN];
  assign v = flags[relative_jump_and_load_pkg::FLAG_OVFL];

  // Sixteen condition variants
  always_comb begin
    case (condSel)
      relative_jump_and_load_pkg::CC_NEVER: condTrue = 1'b0;
      relative_jump_and_load_pkg::CC_LT:    condTrue = s ^ v;
      relative_jump_and_load_pkg::CC_LE:    condTrue = z | (s ^ v);
      relative_jump_and_load_pkg::CC_ULE:   condTrue = c | z;
      relative_jump_and_load_pkg::CC_OV:    condTrue = v;
      relative_jump_and_load_pkg::CC_MI:    condTrue = s;
      relative_jump_and_load_pkg::CC_EQ:    condTrue = z;
      relative_jump_and_load_pkg::CC_CY:    condTrue = c;
      relative_jump_and_load_pkg::CC_ALL:   condTrue = 1'b1;
      relative_jump_and_load_pkg::CC_GE:    condTrue = ~(s ^ v);
      relative_jump_and_load_pkg::CC_GT:    condTrue = ~(z | (s ^ v));
      relative_jump_and_load_pkg::CC_UGT:   condTrue = ~(c | z);
      relative_jump_and_load_pkg::CC_NOV:   condTrue = ~v;
      relative_jump_and_load_pkg::CC_PL:    condTrue = ~s;
      relative_jump_and_load_pkg::CC_NE:    condTrue = ~z;
      relative_jump_and_load_pkg::CC_NC:    condTrue = ~c;
      default:                              condTrue = 1'b0;
    endcase
  end
endmodule : condition_eval
`default_nettype wire

// file: tb_relative_jump_and_load_exec.sv
// Purpose: Self-checking bench for the branch and byte move executor
// Assumes: Inputs change at the falling edge
// Notes:   Each scenario resets, loads a program and judges register results
`timescale 1ns/1ps
`default_nettype none
module tb_relative_jump_and_load_exec;
  localparam int PC_W = 16;
  logic sys_clk = 1'b0;
  logic sys_rst;
  logic [7:0] fetchData, regRdData, flags, workBase, regRdAddr;
  logic [PC_W-1:0] fetchAddr;
  relative_jump_and_load_pkg::reg_write_type regWr;
  logic instrDone, badOpcode, badSeen;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [PC_W-1:0] trace [$];
  always #5 sys_clk = ~sys_clk;
  relative_jump_and_load_exec #(.PC_W(PC_W), .PC_RESET('0)) dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .fetchData(fetchData), .regRdData(regRdData), .flags(flags),
    .workBase(workBase), .fetchAddr(fetchAddr), .regRdAddr(regRdAddr), .regWr(regWr),
    .instrDone(instrDone), .badOpcode(badOpcode));
  prog_reg_model #(.PC_W(PC_W)) mem (.sys_clk(sys_clk), .fetchAddr(fetchAddr),
    .regRdAddr(regRdAddr), .regWr(regWr), .fetchData(fetchData), .regRdData(regRdData));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk8(input logic [7:0] adr, input logic [7:0] exp, input string what);
    chk({8'h00, mem.regs[adr]}, {8'h00, exp}, what);
  endtask : chk8
  // Reset, clear the registers, fill the program array with FF and load a program at address 0
  task automatic prep(input logic [7:0] base, input logic [7:0] code [$]);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    workBase = base;
    for (int i = 0; i < 256; i++) begin
      mem.prog[i] = (i < code.size()) ? code[i] : 8'hFF;
      mem.regs[i] = 8'h00;
    end
  endtask : prep
  // Release reset and record the opcode address at each instrDone
  task automatic runProg(input int n);
    int k;
    k = 0;
    trace.delete();
    badSeen = 1'b0;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    while (trace.size() < n && k < 40 * n) begin
      @(negedge sys_clk);
      k++;
      if (badOpcode === 1'b1) badSeen = 1'b1;
      if (instrDone === 1'b1) trace.push_back(fetchAddr);
    end
    if (trace.size() < n) chk(16'(trace.size()), 16'(n), "instructions completed");
    repeat (2) @(negedge sys_clk);
  endtask : runProg
  task automatic t_compact();
    prep(8'hC0, '{8'h3C, 8'h5A, 8'h48, 8'h20, 8'h29, 8'h21});
    mem.regs[8'h20] = 8'h77;
    mem.regs[8'hC2] = 8'h99;
    runProg(3);
    chk8(8'hC3, 8'h5A, "immediate to working");
    chk8(8'hC4, 8'h77, "register to working");
    chk8(8'h21, 8'h99, "working to register");
    chk8(8'h20, 8'h77, "source kept");
    chk(trace[2], 16'h0006, "compact lengths");
    $display("compact moves done");
  endtask : t_compact
  task automatic t_indirect();
    prep(8'hB0, '{8'hC7, 8'h12, 8'hD7, 8'h34});
    mem.regs[8'hB2] = 8'h30;
    mem.regs[8'h30] = 8'hAB;
    mem.regs[8'hB3] = 8'h31;
    mem.regs[8'hB4] = 8'h66;
    runProg(2);
    chk8(8'hB1, 8'hAB, "indirect load");
    chk8(8'h31, 8'h66, "indirect store");
    chk8(8'h30, 8'hAB, "indirect source kept");
    chk(trace[1], 16'h0004, "indirect lengths");
    $display("indirect moves done");
  endtask : t_indirect
  task automatic t_three();
    prep(8'hC0, '{8'hE4, 8'h40, 8'h41, 8'hE5, 8'h42, 8'h43, 8'hE6, 8'h44, 8'h5C,
                  8'hD6, 8'h45, 8'h6D, 8'hF5, 8'h46, 8'h47});
    mem.regs[8'h40] = 8'h11;
    mem.regs[8'h42] = 8'h50;
    mem.regs[8'h50] = 8'h22;
    mem.regs[8'h45] = 8'h51;
    mem.regs[8'h46] = 8'h33;
    mem.regs[8'h47] = 8'h52;
    runProg(5);
    chk8(8'h41, 8'h11, "register copy");
    chk8(8'h43, 8'h22, "indirect source copy");
    chk8(8'h44, 8'h5C, "immediate to register");
    chk8(8'h51, 8'h6D, "immediate to indirect");
    chk8(8'h52, 8'h33, "register to indirect");
    chk8(8'h46, 8'h33, "three byte source kept");
    chk(trace[4], 16'h000F, "three byte lengths");
    $display("three byte moves done");
  endtask : t_three
  task automatic t_indexed();
    prep(8'hC0, '{8'h87, 8'h15, 8'h60, 8'h97, 8'h26, 8'h70});
    mem.regs[8'hC5] = 8'h03;
    mem.regs[8'h63] = 8'hE1;
    mem.regs[8'hC6] = 8'hFF;
    mem.regs[8'hC2] = 8'h9D;
    runProg(2);
    chk8(8'hC1, 8'hE1, "indexed load");
    chk8(8'h6F, 8'h9D, "indexed store wraps");
    chk(trace[1], 16'h0006, "indexed lengths");
    $display("indexed moves done");
  endtask : t_indexed
  task automatic t_branch();
    flags = 8'hA5;
    prep(8'hC0, '{8'h0B, 8'h10, 8'h8B, 8'h04, 8'h4C, 8'h01, 8'h3C, 8'h55, 8'h7B, 8'hFC});
    runProg(4);
    chk(trace[0], 16'h0002, "never falls through");
    chk(trace[1], 16'h0008, "forward branch");
    chk(trace[2], 16'h0006, "backward branch");
    chk(trace[3], 16'h0008, "loop return");
    chk8(8'hC4, 8'h00, "skipped code unrun");
    chk8(8'hC3, 8'h55, "branch target run");
    flags = 8'h00;
    $display("branches done");
  endtask : t_branch
  task automatic t_bad();
    prep(8'hC0, '{8'hFF, 8'h3C, 8'h12, 8'h6B, 8'h02});
    runProg(3);
    chk(trace[2], 16'h0005, "false condition falls through");
    chk(trace[0], 16'h0001, "unknown opcode skipped");
    chk({15'h0000, badSeen}, 16'h0001, "unknown opcode flagged");
    chk8(8'hC3, 8'h12, "move after unknown");
    $display("unknown opcode done");
  endtask : t_bad
  // Cut a hung run short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("wrong value at %0t: run timed out", $time);
      final_report();
    end
  end
  initial begin
    sys_rst = 1'b1;
    flags = 8'h00;
    workBase = 8'hC0;
    t_compact();
    t_indirect();
    t_three();
    t_indexed();
    t_branch();
    t_bad();
    final_report();
  end
endmodule : tb_relative_jump_and_load_exec
bind relative_jump_and_load_exec relative_jump_and_load_exec_properties #(.PC_W(PC_W)) props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .fetchData(fetchData), .regRdData(regRdData),
  .flags(flags), .workBase(workBase), .fetchAddr(fetchAddr), .regRdAddr(regRdAddr),
  .regWr(regWr), .instrDone(instrDone), .badOpcode(badOpcode));
`default_nettype wire
